/* File: design/fbsr_defines.svh */
// constants for the four-bit shift register
`ifndef FBSR_DEFINES_SVH
`define FBSR_DEFINES_SVH

`define FBSR_WIDTH        4
`define FBSR_SYNC_STAGES  2
`define FBSR_RESET_VALUE  4'h0
`define FBSR_SOUT_N_RESET 1'h1
`define FBSR_MODE_HOLD    2'h0
`define FBSR_MODE_LOAD    2'h1
`define FBSR_MODE_SHIFT   2'h2

`endif

/* File: design/fbsr_pkg.sv */
// types and mode decode for the four-bit shift register
`include "fbsr_defines.svh"

package fbsr_pkg;

	// operation chosen by the two mode pins
	typedef enum logic [1:0] {
		FBSR_HOLD  = 2'b00,
		FBSR_LOAD  = 2'b01,
		FBSR_SHIFT = 2'b10
	} fbsr_mode_type;

	// pins driven by the surrounding logic, apart from the shift clock and the direct clear
	typedef struct packed {
		logic                   par_enter; // parallel-entry select
		logic                   shift;     // shift-right select
		logic                   serial_in; // serial data into stage 0
		logic [`FBSR_WIDTH-1:0] par_data;  // parallel data, bit i to stage i
	} fbsr_ctrl_type;

	// shift wins over parallel entry; both low holds
	function automatic fbsr_mode_type fbsr_decode(
		input logic par_enter,
		input logic shift
	);
		if (shift) begin
			return FBSR_SHIFT;
		end else if (par_enter) begin
			return FBSR_LOAD;
		end
		return FBSR_HOLD;
	endfunction

endpackage

/* File: design/fbsr_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module fbsr_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// asynchronous pins in
	input  wire logic [WIDTH-1:0] d,
	// synchronised levels out
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage1; // first flop, read only by the second

	// two stages: metastability settles before any logic looks
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end

endmodule

`default_nettype wire

/* File: design/fbsr_top.sv */
// four-bit shift register with serial and parallel entry
`timescale 1ns/1ps
`default_nettype none

module fbsr_top (
	// core clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	// pins from the surrounding logic
	input  wire logic                    shift_clk,
	input  wire logic                    clear_n,
	input  wire fbsr_pkg::fbsr_ctrl_type ctrl,
	// register outputs
	output var  logic [`FBSR_WIDTH-1:0]  stage_q,
	output var  logic                    serial_out,
	output var  logic                    serial_out_n
);

	import fbsr_pkg::*;

	localparam int WIDTH  = `FBSR_WIDTH;
	localparam int SYNC_W = $bits(fbsr_ctrl_type) + 2;

	logic [SYNC_W-1:0] sync_in;     // raw pins bundled
	logic [SYNC_W-1:0] sync_out;    // pins after two flops
	logic              clk_s;       // synchronised shift clock
	logic              clear_s_n;   // synchronised direct clear
	fbsr_ctrl_type     ctrl_s;      // synchronised mode and data
	logic              clk_prev;    // shift clock one cycle back
	logic              fall;        // shift clock high-to-low seen
	fbsr_mode_type     mode;        // decoded operation
	logic [WIDTH-1:0]  stage;       // the four stages
	logic [WIDTH-1:0]  next_stage;  // value for the next core edge

	// shift path as a net: one continuous assignment per stage bit
	wire logic [WIDTH-1:0] shifted;

	// all pins share one synchroniser so data and clock stay aligned
	assign sync_in = {shift_clk, clear_n, ctrl};

	// two core cycles pass before any pin is seen inside
	fbsr_sync #(
		.WIDTH (SYNC_W)
	) fbsr_sync_inst (
		.core_clk (core_clk),
		.resetn   (resetn),
		.d        (sync_in),
		.q        (sync_out)
	);

	assign clk_s     = sync_out[SYNC_W-1];
	assign clear_s_n = sync_out[SYNC_W-2];
	assign ctrl_s    = fbsr_ctrl_type'(sync_out[SYNC_W-3:0]);

	// remember the shift clock level for edge detection
	// reset to the idle low level of the pin, so no false fall follows
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			clk_prev <= 1'h0;
		end else begin
			clk_prev <= clk_s;
		end
	end

	// only the falling edge counts; rising edges do nothing
	assign fall = clk_prev & ~clk_s;

	assign mode = fbsr_decode(ctrl_s.par_enter, ctrl_s.shift);

	// each stage takes its left neighbour; stage 0 takes the serial input,
	// and the old bit of the last stage falls off the end
	assign shifted[0] = ctrl_s.serial_in;

	for (genvar i = 1; i < WIDTH; i++) begin : g_shift
		assign shifted[i] = stage[i-1];
	end

	// next value: clear first, then the mode on a falling edge
	always_comb begin
		next_stage = stage;
		if (!clear_s_n) begin
			// clear needs no shift clock edge
			next_stage = `FBSR_RESET_VALUE;
		end else if (fall) begin
			case (mode)
				FBSR_LOAD: begin
					next_stage = ctrl_s.par_data;
				end
				FBSR_SHIFT: begin
					next_stage = shifted;
				end
				FBSR_HOLD: begin
					next_stage = stage;
				end
				default: begin
					next_stage = stage;
				end
			endcase
		end
	end

	// the register itself
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			stage <= `FBSR_RESET_VALUE;
		end else begin
			stage <= next_stage;
		end
	end

	// complement kept in its own flop so the output is registered
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			serial_out_n <= `FBSR_SOUT_N_RESET;
		end else begin
			serial_out_n <= ~next_stage[WIDTH-1];
		end
	end

	// true outputs taken straight from the stage flops
	assign stage_q    = stage;
	assign serial_out = stage[WIDTH-1];

	// limitation: the pins are sampled on the core clock, so each shift
	// clock level must stand for at least two core cycles to be seen;
	// the shared synchroniser costs two core cycles of latency but
	// keeps mode, data and clock aligned
	// checks on the register behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence edge_shift_s;
		fall && clear_s_n && (mode == FBSR_SHIFT);
	endsequence

	sequence edge_load_s;
		fall && clear_s_n && (mode == FBSR_LOAD);
	endsequence

	sequence edge_hold_s;
		fall && clear_s_n && (mode == FBSR_HOLD);
	endsequence

	sequence pin_fall_s;
		$fell(shift_clk) ##1 !shift_clk;
	endsequence

	edge_from_pin_a: assert property (
		pin_fall_s |-> ##1 fall
	) else $error("shift clock fall not detected");

	no_edge_still_a: assert property (
		(!fall && clear_s_n) |=> $stable(stage_q)
	) else $error("stages changed without a falling edge");

	hold_keeps_a: assert property (
		edge_hold_s |=> $stable(stage_q)
	) else $error("hold mode changed the stages");

	shift_moves_a: assert property (
		edge_shift_s |=> (stage_q ==
			{$past(stage_q[WIDTH-2:0]), $past(ctrl_s.serial_in)})
	) else $error("shift right moved the wrong bits");

	load_copies_a: assert property (
		edge_load_s |=> (stage_q == $past(ctrl_s.par_data))
	) else $error("parallel load did not copy the inputs");

	shift_priority_a: assert property (
		ctrl_s.shift |-> (mode == FBSR_SHIFT)
	) else $error("shift select did not win");

	load_decode_a: assert property (
		(ctrl_s.par_enter && !ctrl_s.shift) |-> (mode == FBSR_LOAD)
	) else $error("parallel entry not decoded");

	clear_wins_a: assert property (
		!clear_s_n |=> (stage_q == `FBSR_RESET_VALUE) && serial_out_n
	) else $error("direct clear did not zero the stages");

	comp_out_a: assert property (
		serial_out_n != serial_out
	) else $error("complement output equals serial output");

	// a bit shifted in walks to the last stage; four falls bring it out
	serial_tail_a: assert property (
		edge_shift_s |=> (serial_out == $past(stage_q[WIDTH-2]))
	) else $error("last stage did not take its neighbour");

	// every stage but the first takes its left neighbour on a shift
	for (genvar j = 1; j < WIDTH; j++) begin : g_shift_chk
		stage_moves_a: assert property (
			edge_shift_s |=> (stage_q[j] == $past(stage_q[j-1]))
		) else $error("a stage did not take its left neighbour");
	end

	// a rising shift clock must leave the stages alone
	rise_ignored_a: assert property (
		($rose(clk_s) && clear_s_n) |=> $stable(stage_q)
	) else $error("stages changed on a rising shift clock");

	// one pin fall acts once, never twice
	fall_once_a: assert property (
		fall |=> !fall
	) else $error("one shift clock fall seen twice");

	// clear pin low for three core cycles has emptied the register
	sequence pin_clear_s;
		(!clear_n) [*3];
	endsequence

	clear_from_pin_a: assert property (
		pin_clear_s |=> (stage_q == `FBSR_RESET_VALUE)
	) else $error("clear pin did not empty the stages");

endmodule

`default_nettype wire

/* File: verification/fbsr_host.sv */
// model of the system logic driving the register pins
`timescale 1ns/1ps
`default_nettype none

module fbsr_host (
	// core clock
	input  wire logic                    core_clk,
	// pins into the register
	output var  logic                    shift_clk,
	output var  logic                    clear_n,
	output var  fbsr_pkg::fbsr_ctrl_type ctrl
);
	import fbsr_pkg::*;

	// idle: clock low, clear off
	initial begin
		shift_clk = 1'b0;
		clear_n = 1'b1;
		ctrl = '0;
	end

	// move the shift clock and the controls together, then hold them
	// four cycles so the synchroniser sees each level; the mode and the
	// data stay put past the fall, as the register expects
	task automatic edge_to(input logic level, input fbsr_ctrl_type c);
		@(posedge core_clk);
		shift_clk <= level;
		ctrl <= c;
		repeat (4) @(posedge core_clk);
	endtask

	// drive the direct clear level; no shift clock edge involved
	task automatic clear(input logic level);
		@(posedge core_clk);
		clear_n <= level;
		repeat (4) @(posedge core_clk);
	endtask
endmodule

`default_nettype wire

/* File: verification/four_bit_shift_register_tb.sv */
// self-checking bench for the four-bit shift register
`timescale 1ns/1ps
`default_nettype none

module four_bit_shift_register_tb;
	import fbsr_pkg::*;
	logic          core_clk;     // 25 MHz core clock
	logic          resetn;       // core reset, active low
	logic          shift_clk;    // pin from the host model
	logic          clear_n;      // pin from the host model
	fbsr_ctrl_type ctrl;         // pins from the host model
	logic [3:0]    stage_q;      // stage outputs
	logic          serial_out;   // last stage
	logic          serial_out_n; // its complement
	int            bad_count;    // mismatches seen
	int            compares;     // comparisons made

	fbsr_host fbsr_host_inst (.core_clk(core_clk), .shift_clk(shift_clk),
		.clear_n(clear_n), .ctrl(ctrl));
	fbsr_top fbsr_top_inst (.core_clk(core_clk), .resetn(resetn),
		.shift_clk(shift_clk), .clear_n(clear_n), .ctrl(ctrl),
		.stage_q(stage_q), .serial_out(serial_out),
		.serial_out_n(serial_out_n));

	// clock generator
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// verdict and end of run
	task automatic complete_run();
		if (bad_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// stages, serial output and its complement against one value
	task automatic chk_q(input string name, input logic [3:0] exp);
		compares++;
		if (stage_q !== exp || serial_out !== exp[3] ||
			serial_out_n !== ~exp[3]) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h %b %b", name, exp,
				stage_q, serial_out, serial_out_n);
		end
	endtask

	// one shift clock pulse; the rise alone must change nothing
	task automatic op(input string name, input logic pe, sh, si,
		input logic [3:0] pd, exp);
		logic [3:0] old;
		old = stage_q;
		fbsr_host_inst.edge_to(1'b1, '{pe, sh, si, pd});
		chk_q({name, "_rise"}, old);
		fbsr_host_inst.edge_to(1'b0, '{pe, sh, si, pd});
		chk_q(name, exp);
	endtask

	// load, hold, shift with and without parallel entry
	task automatic t_modes();
		logic [3:0] exp;
		op("load", 1'b1, 1'b0, 1'b0, 4'hA, 4'hA);
		op("hold", 1'b0, 1'b0, 1'b1, 4'h5, 4'hA);
		op("shift_pe", 1'b1, 1'b1, 1'b0, 4'hF, 4'h4);
		exp = 4'h4;
		for (int i = 0; i < 4; i++) begin
			exp = {exp[2:0], 1'b1};
			op("shift", 1'b0, 1'b1, 1'b1, 4'h0, exp);
		end
	endtask

	// direct clear acts alone and beats a load
	task automatic t_clear();
		fbsr_host_inst.clear(1'b0);
		chk_q("clear", 4'h0);
		op("clear_load", 1'b1, 1'b0, 1'b0, 4'h9, 4'h0);
		fbsr_host_inst.clear(1'b1);
		chk_q("clear_off", 4'h0);
	endtask

	// parallel entry tied high, shift alone picks the operation
	task automatic t_tied();
		op("tied_load", 1'b1, 1'b0, 1'b1, 4'h6, 4'h6);
		op("tied_shift", 1'b1, 1'b1, 1'b1, 4'h0, 4'hD);
	endtask

	// core reset in mid-run empties the stages, then a load works again
	task automatic t_reset();
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk_q("core_reset", 4'h0);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk_q("core_reset_off", 4'h0);
		op("reset_load", 1'b1, 1'b0, 1'b0, 4'h3, 4'h3);
	endtask

	// main sequence
	initial begin
		bad_count = 0;
		compares = 0;
		resetn = 1'b0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk_q("reset", 4'h0);
		t_modes();
		t_clear();
		t_tied();
		t_reset();
		complete_run();
	end

	// hang guard
	initial begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		complete_run();
	end
endmodule

`default_nettype wire
